// file: swc_pkg.sv
// ----------------------------------------------------------------------
// Summary of operation
// ----------------------------------------------------------------------
package swc_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned RST_PULSE_NS = 1000;
    localparam int unsigned RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] SWITCH_CONTROL_OFFSET = 12'h32c;
    localparam logic [31:0] SWITCH_CONTROL_RESET = 32'h00000000;
    localparam logic [31:0] RW_MASK = 32'h0007c1ec;
    localparam logic [31:0] RWL_MASK = 32'h00000010;
    localparam logic [31:0] FR_STICKY_MASK = 32'h00030000;

    localparam int FULL_RESET_TRIGGER_BIT = 0;
    localparam int WARM_RESET_TRIGGER_BIT = 1;
    localparam int RESET_HOLD_BIT = 2;
    localparam int LOCKED_FIELD_UNLOCK_BIT = 3;
    localparam int POWER_BUDGET_UNLOCK_BIT = 4;
    localparam int LINK_DOWN_WARM_RESET_DISABLE_BIT = 5;
    localparam int WARM_RESET_EEPROM_LOAD_SKIP_BIT = 6;
    localparam int RELAXED_ORDERING_DISABLE_BIT = 7;
    localparam int PEER_TRAFFIC_DISABLE_BIT = 8;
    localparam int CUT_THROUGH_DISABLE_BIT = 14;
    localparam int LOCKED_REQUEST_IGNORE_BIT = 15;
    localparam int WAKE_PIN_DIRECTION_BIT = 16;
    localparam int AUX_SUPPLY_ENABLE_BIT = 17;
    localparam int VENDOR_BROADCAST_DISCARD_BIT = 18;

    localparam logic [2:0] SWITCH_MODE_EEPROM = 3'h1;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_PULSE,
        SEQ_LOAD,
        SEQ_HOLD
    } swc_seq_state_t;

endpackage

// file: swc_seq_if.sv
`timescale 1ns/100ps
interface swc_seq_if;
    logic fund_req;
    logic hot_req;
    logic eeprom_mode;
    logic load_skip;
    logic hold;
    logic ee_done;
    logic start;
    logic fund_start;
    logic core_rst;
    logic load_phase;
    logic idle;

    modport ctl(output fund_req, hot_req, eeprom_mode, load_skip, hold, ee_done,
        input start, fund_start, core_rst, load_phase, idle);
    modport seq(input fund_req, hot_req, eeprom_mode, load_skip, hold, ee_done,
        output start, fund_start, core_rst, load_phase, idle);
endinterface

// file: swc_reset_seq.sv
`timescale 1ns/100ps
module swc_reset_seq
    import swc_pkg::*;
#(
    parameter int unsigned PULSE_CYC = RST_PULSE_CYC
) (
    input wire logic clk_i, // System clock
    input wire logic rst_n_i, // Aux power-on reset
    swc_seq_if.seq sq // Sequencer control
);
    localparam int CNT_W = $clog2(PULSE_CYC + 1);

    swc_seq_state_t state;
    swc_seq_state_t next_state;
    logic [CNT_W-1:0] cnt;
    logic need_load;

    // A fundamental request restarts any sequence; hot only from idle
    wire start_fund = sq.fund_req;
    wire start_hot = sq.hot_req & (state == SEQ_IDLE);
    wire start_any = start_fund | start_hot;
    wire cnt_done = (cnt == CNT_W'(PULSE_CYC - 1));
    wire next_need_load = sq.eeprom_mode & (start_fund | ~sq.load_skip);

    always_comb begin
        next_state = state;
        if (start_any) begin
            next_state = SEQ_PULSE;
        end else begin
            unique case (state)
                SEQ_IDLE: next_state = SEQ_IDLE;
                SEQ_PULSE: if (cnt_done) begin
                    next_state = need_load ? SEQ_LOAD : SEQ_HOLD;
                end
                SEQ_LOAD: if (sq.ee_done) begin
                    next_state = SEQ_HOLD;
                end
                SEQ_HOLD: if (!sq.hold) begin
                    next_state = SEQ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= SEQ_IDLE;
            cnt <= '0;
            need_load <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= (start_any || state != SEQ_PULSE) ? '0 : cnt + 1'b1;
            if (start_any) begin
                need_load <= next_need_load;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sq.start <= 1'b0;
            sq.fund_start <= 1'b0;
            sq.core_rst <= 1'b0;
            sq.load_phase <= 1'b0;
        end else begin
            sq.start <= start_any;
            sq.fund_start <= start_fund;
            sq.core_rst <= (next_state != SEQ_IDLE);
            sq.load_phase <= (next_state == SEQ_LOAD);
        end
    end

    assign sq.idle = (state == SEQ_IDLE);
endmodule

// file: swc_ctl.sv
`timescale 1ns/100ps
module swc_ctl
    import swc_pkg::*;
#(
    parameter int unsigned PULSE_CYC = RST_PULSE_CYC
) (
    input wire logic CLK_I, // 10 MHz clock
    input wire logic RST_N_I, // Aux power-on reset
    input wire logic [11:0] ADDR_I, // Register byte address
    input wire logic [31:0] WDATA_I, // Write data
    input wire logic WR_I, // Write strobe
    input wire logic RD_I, // Read strobe
    output logic [31:0] RDATA_O, // Read data, cycle after strobe
    input wire logic FUND_RST_I, // External fundamental reset request
    input wire logic HOT_RST_I, // In-band hot reset request
    input wire logic LINK_DOWN_I, // Upstream link entered DL_Down
    input wire logic [2:0] SWITCH_MODE_I, // Operating mode straps
    input wire logic RESET_HOLD_PIN_I, // Reset hold strap
    input wire logic AUX_SUPPLY_DISABLE_PIN_N_I, // Aux supply disable pin
    input wire logic EE_DONE_I, // EEPROM load finished
    input wire logic EE_ERR_I, // EEPROM load error
    input wire logic WAKE_REQ_I, // Request to drive wake
    input wire logic WAKE_PIN_N_I, // Wake pin level
    output logic WAKE_PIN_N_O, // Wake pin drive value
    output logic WAKE_PIN_N_OE_N_O, // Wake pin enable, low drives
    output logic WAKE_EVENT_O, // Wake seen on input pin
    output logic SWITCH_RST_O, // Switch core held in reset
    output logic EE_LOAD_O, // EEPROM load step active
    output logic LOCKED_FIELD_UNLOCK_O, // Locked fields writable
    output logic POWER_BUDGET_UNLOCK_O, // Budget data writable
    output logic RELAXED_ORDERING_DISABLE_O, // Strong ordering
    output logic PEER_TRAFFIC_DISABLE_O, // Block peer traffic
    output logic CUT_THROUGH_DISABLE_O, // Store and forward
    output logic LOCKED_REQUEST_IGNORE_O, // Locked requests plain
    output logic AUX_SUPPLY_ENABLE_O, // Aux supply use allowed
    output logic VENDOR_BROADCAST_DISCARD_O // Drop vendor broadcasts
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [31:0] ctl;
    logic por_pending;

    swc_seq_if sq();

    swc_reset_seq #(
        .PULSE_CYC(PULSE_CYC)
    ) u_seq (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .sq(sq)
    );

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire wr_hit = WR_I & (ADDR_I == SWITCH_CONTROL_OFFSET);
    wire rd_hit = RD_I & (ADDR_I == SWITCH_CONTROL_OFFSET);
    wire full_trig = wr_hit & WDATA_I[FULL_RESET_TRIGGER_BIT];
    wire warm_trig = wr_hit & WDATA_I[WARM_RESET_TRIGGER_BIT];
    wire link_down_hot = LINK_DOWN_I & ~ctl[LINK_DOWN_WARM_RESET_DISABLE_BIT];

    // First edge after power-on runs a fundamental reset
    assign sq.fund_req = por_pending | full_trig | FUND_RST_I;
    assign sq.hot_req = warm_trig | HOT_RST_I | link_down_hot;
    assign sq.eeprom_mode = (SWITCH_MODE_I == SWITCH_MODE_EEPROM);
    assign sq.load_skip = ctl[WARM_RESET_EEPROM_LOAD_SKIP_BIT];
    assign sq.hold = ctl[RESET_HOLD_BIT];
    assign sq.ee_done = EE_DONE_I;

    // ------------------------------------------------------------------
    // Next register value
    // ------------------------------------------------------------------
    // locked bits writable only when unlocked
    wire [31:0] wr_mask = RW_MASK | (ctl[LOCKED_FIELD_UNLOCK_BIT] ? RWL_MASK : 32'h00000000);
    // only defined bits are ever stored
    wire [31:0] after_wr = wr_hit ? ((ctl & ~wr_mask) | (WDATA_I & wr_mask)) : ctl;
    // hot start touches only the unlock bit of the register
    // fundamental clears sticky, keeps aux-surviving bits
    wire [31:0] after_fund = sq.fund_start ? (SWITCH_CONTROL_RESET | (after_wr & FR_STICKY_MASK))
        : after_wr;
    // error sets hold; strap reloads it on fundamental reset
    wire next_hold = EE_ERR_I | (sq.fund_start ? RESET_HOLD_PIN_I : after_fund[RESET_HOLD_BIT]);
    // set during reset operation, set wins over a clear
    wire next_unlock = sq.start | after_fund[LOCKED_FIELD_UNLOCK_BIT];
    // loads inverse of disable pin at aux power-on
    wire next_aux_en = por_pending ? ~AUX_SUPPLY_DISABLE_PIN_N_I : after_fund[AUX_SUPPLY_ENABLE_BIT];

    logic [31:0] next_ctl;
    always_comb begin
        next_ctl = after_fund;
        next_ctl[RESET_HOLD_BIT] = next_hold;
        next_ctl[LOCKED_FIELD_UNLOCK_BIT] = next_unlock;
        next_ctl[AUX_SUPPLY_ENABLE_BIT] = next_aux_en;
    end

    // ------------------------------------------------------------------
    // Flip-flops
    // ------------------------------------------------------------------
    // direction clears with aux power-on
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ctl <= SWITCH_CONTROL_RESET;
            por_pending <= 1'b1;
        end else begin
            ctl <= next_ctl;
            por_pending <= 1'b0;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            RDATA_O <= 32'h00000000;
        end else begin
            RDATA_O <= rd_hit ? ctl : 32'h00000000;
        end
    end

    // Open-drain wake: drive low only as an output and on request
    // direction selects drive
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            WAKE_PIN_N_O <= 1'b0;
            WAKE_PIN_N_OE_N_O <= 1'b1;
            WAKE_EVENT_O <= 1'b0;
        end else begin
            WAKE_PIN_N_O <= 1'b0;
            WAKE_PIN_N_OE_N_O <= ~(next_ctl[WAKE_PIN_DIRECTION_BIT] & WAKE_REQ_I);
            WAKE_EVENT_O <= ~next_ctl[WAKE_PIN_DIRECTION_BIT] & ~WAKE_PIN_N_I;
        end
    end

    // ------------------------------------------------------------------
    // Outputs straight from flops
    // ------------------------------------------------------------------
    // core held while the sequencer is busy
    assign SWITCH_RST_O = sq.core_rst;
    assign EE_LOAD_O = sq.load_phase;
    assign LOCKED_FIELD_UNLOCK_O = ctl[LOCKED_FIELD_UNLOCK_BIT];
    assign POWER_BUDGET_UNLOCK_O = ctl[POWER_BUDGET_UNLOCK_BIT];
    assign RELAXED_ORDERING_DISABLE_O = ctl[RELAXED_ORDERING_DISABLE_BIT];
    assign PEER_TRAFFIC_DISABLE_O = ctl[PEER_TRAFFIC_DISABLE_BIT];
    assign CUT_THROUGH_DISABLE_O = ctl[CUT_THROUGH_DISABLE_BIT];
    assign LOCKED_REQUEST_IGNORE_O = ctl[LOCKED_REQUEST_IGNORE_BIT];
    assign AUX_SUPPLY_ENABLE_O = ctl[AUX_SUPPLY_ENABLE_BIT];
    assign VENDOR_BROADCAST_DISCARD_O = ctl[VENDOR_BROADCAST_DISCARD_BIT];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    chk_full_trigger: assert property (
        full_trig |=> SWITCH_RST_O ##1 !ctl[PEER_TRAFFIC_DISABLE_BIT])
        else $error("full reset trigger did not reset the switch");

    chk_trig_readzero: assert property (
        rd_hit |=> (RDATA_O[1:0] == 2'h0))
        else $error("trigger bits read nonzero");

    chk_reserved_zero: assert property (
        rd_hit |=> ((RDATA_O & ~(RW_MASK | RWL_MASK)) == 32'h00000000))
        else $error("reserved bits read nonzero");

    chk_hold_keeps: assert property (
        (u_seq.state == SEQ_HOLD && ctl[RESET_HOLD_BIT] && !EE_ERR_I) [*2] |-> SWITCH_RST_O)
        else $error("switch left reset while hold set");

    chk_hold_idle: assert property (
        (sq.idle && !SWITCH_RST_O && !sq.fund_req && !sq.hot_req)
        |=> !SWITCH_RST_O)
        else $error("hold bit acted outside a reset");

    chk_eeprom_error: assert property (
        EE_ERR_I |=> ctl[RESET_HOLD_BIT])
        else $error("eeprom error did not set hold");

    chk_locked_write: assert property (
        (wr_hit && !ctl[LOCKED_FIELD_UNLOCK_BIT] && !sq.fund_start)
        |=> $stable(ctl[POWER_BUDGET_UNLOCK_BIT]))
        else $error("locked field written while locked");

    chk_unlock_set: assert property (
        sq.start |=> ctl[LOCKED_FIELD_UNLOCK_BIT])
        else $error("unlock not set during reset");

    chk_linkdown_off: assert property (
        (LINK_DOWN_I && ctl[LINK_DOWN_WARM_RESET_DISABLE_BIT] && sq.idle && !SWITCH_RST_O
        && !HOT_RST_I && !warm_trig && !sq.fund_req) |=> !SWITCH_RST_O)
        else $error("disabled link down caused reset");

    chk_hot_sticky: assert property (
        (sq.start && !sq.fund_start && !wr_hit && !EE_ERR_I && !por_pending)
        |=> (ctl & ~32'h00000008) == ($past(ctl) & ~32'h00000008))
        else $error("hot reset changed sticky fields");

    chk_warm_trigger: assert property (
        (warm_trig && sq.idle) |=> SWITCH_RST_O)
        else $error("warm reset trigger did not reset the switch");

    chk_hold_release: assert property (
        (u_seq.state == SEQ_HOLD && !ctl[RESET_HOLD_BIT] && !sq.fund_req) |=> !SWITCH_RST_O)
        else $error("switch stayed in reset after hold cleared");

    chk_skip_load: assert property (
        (sq.hot_req && sq.idle && !sq.fund_req && sq.load_skip) |=> !u_seq.need_load)
        else $error("warm reset kept the eeprom load step");

    chk_load_phase: assert property (
        (u_seq.state == SEQ_PULSE && !u_seq.need_load) |=> !EE_LOAD_O)
        else $error("eeprom load step entered when skipped");

    chk_budget_write: assert property (
        (wr_hit && ctl[LOCKED_FIELD_UNLOCK_BIT] && !sq.fund_start)
        |=> POWER_BUDGET_UNLOCK_O == $past(WDATA_I[POWER_BUDGET_UNLOCK_BIT]))
        else $error("budget unlock not written while unlocked");

    chk_order_write: assert property (
        (wr_hit && !sq.fund_start)
        |=> RELAXED_ORDERING_DISABLE_O == $past(WDATA_I[RELAXED_ORDERING_DISABLE_BIT]))
        else $error("ordering control not written");

    chk_peer_write: assert property (
        (wr_hit && !sq.fund_start)
        |=> PEER_TRAFFIC_DISABLE_O == $past(WDATA_I[PEER_TRAFFIC_DISABLE_BIT]))
        else $error("peer traffic control not written");

    chk_route_write: assert property (
        (wr_hit && !sq.fund_start)
        |=> CUT_THROUGH_DISABLE_O == $past(WDATA_I[CUT_THROUGH_DISABLE_BIT]))
        else $error("routing mode not written");

    chk_lockreq_write: assert property (
        (wr_hit && !sq.fund_start)
        |=> LOCKED_REQUEST_IGNORE_O == $past(WDATA_I[LOCKED_REQUEST_IGNORE_BIT]))
        else $error("locked request control not written");

    chk_bcast_write: assert property (
        (wr_hit && !sq.fund_start)
        |=> VENDOR_BROADCAST_DISCARD_O == $past(WDATA_I[VENDOR_BROADCAST_DISCARD_BIT]))
        else $error("broadcast discard not written");

    chk_aux_poweron: assert property (
        por_pending |=> AUX_SUPPLY_ENABLE_O == !$past(AUX_SUPPLY_DISABLE_PIN_N_I))
        else $error("aux enable not loaded from pin");

    chk_wake_dir: assert property (
        !ctl[WAKE_PIN_DIRECTION_BIT] |-> WAKE_PIN_N_OE_N_O)
        else $error("wake pin driven while an input");

    chk_wake_clear: assert property (
        (por_pending && !wr_hit) |=> !ctl[WAKE_PIN_DIRECTION_BIT])
        else $error("wake direction not clear at power-on");

    chk_fund_sticky: assert property (
        (sq.fund_start && !wr_hit && !por_pending)
        |=> ((ctl & FR_STICKY_MASK) == ($past(ctl) & FR_STICKY_MASK)))
        else $error("fundamental reset changed aux fields");

    chk_fund_clear: assert property (
        sq.fund_start |=> ((ctl & ~FR_STICKY_MASK & ~32'h0000000c) == 32'h00000000))
        else $error("fundamental reset left sticky fields set");

    chk_reserved_store: assert property (
        wr_hit |=> ((ctl & ~(RW_MASK | RWL_MASK)) == 32'h00000000))
        else $error("reserved bits stored");

    chk_linkdown_on: assert property (
        (LINK_DOWN_I && !ctl[LINK_DOWN_WARM_RESET_DISABLE_BIT] && sq.idle)
        |=> SWITCH_RST_O)
        else $error("link down did not cause a warm reset");

endmodule

// file: test_swc_ctl.sv
`timescale 1ns/100ps
module test_swc_ctl import swc_pkg::*;;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [11:0] ua;
    logic [31:0] wdata = 32'h00000000, rdata, expv, q, w;
    logic fund = 1'b0, hot = 1'b0, ldown = 1'b0, hold_pin = 1'b0, aux_n = 1'b0;
    logic ee_done = 1'b0, ee_err = 1'b0, wreq = 1'b0, wpin_n = 1'b1, load_seen = 1'b0;
    logic [2:0] mode = 3'h0;
    logic wake_o, wake_oe_n, wake_ev, sw_rst, ee_load;
    wire [7:0] flags_o;
    int n_errors = 0, checks_done = 0;

    swc_ctl #(.PULSE_CYC(2)) swc_ctl_inst (.CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .FUND_RST_I(fund),
        .HOT_RST_I(hot), .LINK_DOWN_I(ldown), .SWITCH_MODE_I(mode),
        .RESET_HOLD_PIN_I(hold_pin), .AUX_SUPPLY_DISABLE_PIN_N_I(aux_n),
        .EE_DONE_I(ee_done), .EE_ERR_I(ee_err), .WAKE_REQ_I(wreq), .WAKE_PIN_N_I(wpin_n),
        .WAKE_PIN_N_O(wake_o), .WAKE_PIN_N_OE_N_O(wake_oe_n), .WAKE_EVENT_O(wake_ev),
        .SWITCH_RST_O(sw_rst), .EE_LOAD_O(ee_load), .LOCKED_FIELD_UNLOCK_O(flags_o[0]),
        .POWER_BUDGET_UNLOCK_O(flags_o[1]), .RELAXED_ORDERING_DISABLE_O(flags_o[2]),
        .PEER_TRAFFIC_DISABLE_O(flags_o[3]), .CUT_THROUGH_DISABLE_O(flags_o[4]),
        .LOCKED_REQUEST_IGNORE_O(flags_o[5]), .AUX_SUPPLY_ENABLE_O(flags_o[6]),
        .VENDOR_BROADCAST_DISCARD_O(flags_o[7]));

    always #50 clk = ~clk;
    always @(posedge clk) if (ee_load === 1'b1) load_seen <= 1'b1;

    // Stored value after a write; locked field follows the old unlock bit
    function automatic logic [31:0] nxt(input logic [31:0] o, input logic [31:0] d);
        return (d & RW_MASK) | ((o[3] ? d : o) & RWL_MASK);
    endfunction
    function automatic logic [7:0] flags(input logic [31:0] v);
        return {v[18], v[17], v[15], v[14], v[8], v[7], v[4], v[3]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic wait_rst(input logic lvl);
        int i;
        i = 0;
        while (sw_rst !== lvl && i < 300) begin
            @(posedge clk);
            #1;
            i++;
        end
        chk({31'h0, sw_rst}, {31'h0, lvl}, "switch reset level");
    endtask
    // One-cycle event: 0 link down, 1 eeprom error, else eeprom done
    task automatic pulse(input int sel);
        @(posedge clk);
        case (sel)
            0: ldown <= 1'b1;
            1: ee_err <= 1'b1;
            default: ee_done <= 1'b1;
        endcase
        @(posedge clk);
        ldown <= 1'b0;
        ee_err <= 1'b0;
        ee_done <= 1'b0;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // --------------------------------------------------------------
    // Watchdog
    // --------------------------------------------------------------
    // Tests need about 300 cycles; generous margin
    initial begin
        #(6000 * 100);
        n_errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        tally_and_finish;
    end

    initial begin
        void'($urandom(92));
        repeat (12) @(posedge clk);
        #1;
        chk({30'h0, sw_rst, wake_oe_n}, 32'h1, "outputs in reset");
        rst_n <= 1'b1;
        wait_rst(1'b1);
        wait_rst(1'b0);
        expv = 32'h00020008;
        rd_reg(SWITCH_CONTROL_OFFSET, q);
        chk(q, expv, "value after power-on");
        $display("power-on test done");

        for (int k = 0; k < 24; k++) begin
            w = $urandom();
            w[1:0] = 2'h0;
            if (k % 4 == 0) w[3] = ~expv[3];
            wr_reg(SWITCH_CONTROL_OFFSET, w);
            expv = nxt(expv, w);
            wreq <= $urandom_range(0, 1);
            wpin_n <= $urandom_range(0, 1);
            ua = 12'($urandom());
            if (ua == SWITCH_CONTROL_OFFSET) ua = 12'h330;
            wr_reg(ua, ~w);
            rd_reg(12'h328, q);
            chk(q, 32'h0, "unmapped read");
            rd_reg(SWITCH_CONTROL_OFFSET, q);
            chk(q, expv, "register readback");
            chk({24'h0, flags_o}, {24'h0, flags(expv)}, "control outputs");
            chk({29'h0, wake_o, wake_oe_n, wake_ev},
                {29'h0, 1'b0, ~(expv[16] & wreq), ~expv[16] & ~wpin_n}, "wake pin");
        end
        wreq <= 1'b0;
        wpin_n <= 1'b1;
        $display("random access test done");

        mode <= 3'h1;
        w = (expv & FR_STICKY_MASK) | 32'h0004c1ec;
        wr_reg(SWITCH_CONTROL_OFFSET, w | 32'h2);
        expv = nxt(expv, w);
        load_seen <= 1'b0;
        wait_rst(1'b1);
        repeat (20) @(posedge clk);
        #1;
        chk({31'h0, sw_rst}, 32'h1, "held in reset");
        wr_reg(SWITCH_CONTROL_OFFSET, expv & ~32'h4);
        expv = expv & ~32'h4;
        wait_rst(1'b0);
        chk({31'h0, load_seen}, 32'h0, "load skipped");
        rd_reg(SWITCH_CONTROL_OFFSET, q);
        chk(q, expv, "sticky across warm reset");
        wr_reg(SWITCH_CONTROL_OFFSET, expv | 32'h4);
        expv = expv | 32'h4;
        pulse(0);
        repeat (10) @(posedge clk);
        #1;
        chk({31'h0, sw_rst}, 32'h0, "hold and masked link down");
        wr_reg(SWITCH_CONTROL_OFFSET, expv & ~32'h24);
        expv = expv & ~32'h24;
        pulse(0);
        wait_rst(1'b1);
        wait_rst(1'b0);
        $display("warm reset test done");

        wr_reg(SWITCH_CONTROL_OFFSET, expv | 32'h1);
        load_seen <= 1'b0;
        repeat (300) begin
            @(posedge clk);
            #1;
            if (ee_load === 1'b1) break;
        end
        pulse(1);
        pulse(2);
        repeat (5) @(posedge clk);
        expv = (expv & FR_STICKY_MASK) | 32'hc;
        rd_reg(SWITCH_CONTROL_OFFSET, q);
        chk(q, expv, "full reset value");
        chk({30'h0, load_seen, sw_rst}, 32'h3, "load then hold");
        wr_reg(SWITCH_CONTROL_OFFSET, expv & ~32'h4);
        expv = expv & ~32'h4;
        wait_rst(1'b0);
        rd_reg(SWITCH_CONTROL_OFFSET, q);
        chk(q, expv, "after hold release");
        $display("full reset test done");
        tally_and_finish;
    end
endmodule
